// ===== rtl/clock_buffer_config_map.vh
// Register indices, field positions and reset values of the buffer's
// configuration bank. Definitions only; included by the register block.
`ifndef CLOCK_BUFFER_CONFIG_MAP_VH
`define CLOCK_BUFFER_CONFIG_MAP_VH

// ****************************************
// Register indices (byte offsets on the register port)
// ****************************************
`define REG_EDGE_SPEED 8'h14
`define REG_LOWLOW_DET 8'h15
`define REG_RX_CONFIG 8'h16
`define REG_PERM_LOCK 8'h17
`define REG_CLR_LOCK 8'h18

// ****************************************
// Field positions
// ****************************************
`define LOWLOW_EN_BIT 2
`define BIAS_EN_BIT 1
`define TERM_EN_BIT 0
`define PERM_LOCK_BIT 0
`define CLR_LOCK_BIT 0

// ****************************************
// Reset values
// ****************************************
`define EDGE_SPEED_ALL_FAST 8'hff
`define LOWLOW_RESET 8'h94
`define RX_CONFIG_RESET 8'h00
`define PERM_LOCK_RESET 8'h00
`define CLR_LOCK_RESET 8'h00

// ****************************************
// Start-up timing
// ****************************************
// Last count of the synchroniser fill wait after reset release
`define FILL_LAST 3'h4

`endif

// ===== rtl/clock_buffer_config_regs.v
// Configuration registers of a clock fanout buffer: output edge speed,
// low-low detect enable, input receiver bias/termination, write locks.
// Assumes an SMBus protocol engine on the same clock presents one-cycle
// read and write strobes with a byte address; rst is the power-up reset.
// Strap pins and input legs are asynchronous to clock and pass three
// flops here; the register port is taken as already synchronous.
//
// How it works
// - Source bit 0: strap pin sets edge speeds
// - Source bit 1: all edge speeds fast
// - Host reads and overwrites edge speeds afterwards
// - Edge speed bit n drives output n
// - Detect enable turns receiver off on low-low
// - Detect enable bit 2, resets to 1
// - Bias control bit 1, resets 0 (DC)
// - Termination control bit 0, resets 0
// - Permanent lock blocks writes, reads still work
// - Permanent lock stays set until power cycle
// - Permanent lock resets to 0
// - Clearable lock blocks writes, write-1 toggles
`timescale 1ns/1ps
`default_nettype none
`include "clock_buffer_config_map.vh"

module clock_buffer_config_regs #(
    parameter NUM_OUT = 8
) (
    input wire clock,
    input wire rst,
    input wire slew_default_source_bit,
    input wire edge_speed_strap,
    input wire ref_in_pos,
    input wire ref_in_neg,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    output reg reg_rvalid,
    output reg wr_refused,
    output reg [NUM_OUT-1:0] out_edge_speed,
    output reg receiver_off,
    output reg input_internal_bias_en,
    output reg input_term_en,
    output reg any_lock
);

    // ****************************************
    // Register layout
    // ****************************************
    // 0x14 bit n: edge speed of output n, 1 fast, 0 slow
    // 0x15 bit 2: low-low detect enable, on after reset
    // 0x15 bits 7:3 and 1:0: plain storage, read back as written
    // 0x16 bit 1: internal bias for AC-coupled input sources
    // 0x16 bit 0: termination to ground on both input legs
    // 0x16 bits 7:2: plain storage, read back as written
    // 0x17 bit 0: permanent write lock, set-only
    // 0x18 bit 0: clearable write lock, a written 1 toggles it
    // Other bytes read as 0 and hold nothing.
    //
    // Reads are never refused, locked or not, so the host can
    // always see why a write was dropped.
    // Only a power-up reset undoes the permanent lock; a board that
    // sets it early gives up field reconfiguration for safety.

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // Three stages; a level counts once stages two and three agree
    // Leg level flops reset high, but their stages reset low, so a brief false low-low shows after reset release
    reg [2:0] strap_sync_r;
    reg [2:0] src_sync_r;
    reg [2:0] pos_sync_r;
    reg [2:0] neg_sync_r;
    reg strap_lvl_r;
    reg src_lvl_r;
    reg pos_lvl_r;
    reg neg_lvl_r;

    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            strap_sync_r <= 3'h0;
            src_sync_r <= 3'h0;
            pos_sync_r <= 3'h0;
            neg_sync_r <= 3'h0;
            strap_lvl_r <= 1'b0;
            src_lvl_r <= 1'b0;
            pos_lvl_r <= 1'b1;
            neg_lvl_r <= 1'b1;
        end
        else
        begin
            strap_sync_r <= {strap_sync_r[1:0], edge_speed_strap};
            src_sync_r <= {src_sync_r[1:0], slew_default_source_bit};
            pos_sync_r <= {pos_sync_r[1:0], ref_in_pos};
            neg_sync_r <= {neg_sync_r[1:0], ref_in_neg};
            if (strap_sync_r[1] == strap_sync_r[2])
            begin
                strap_lvl_r <= strap_sync_r[2];
            end
            if (src_sync_r[1] == src_sync_r[2])
            begin
                src_lvl_r <= src_sync_r[2];
            end
            if (pos_sync_r[1] == pos_sync_r[2])
            begin
                pos_lvl_r <= pos_sync_r[2];
            end
            if (neg_sync_r[1] == neg_sync_r[2])
            begin
                neg_lvl_r <= neg_sync_r[2];
            end
        end
    end

    // ****************************************
    // Power-up default capture
    // ****************************************
    // Straps are caught after reset release, once the synchronisers
    // have filled; a constant cannot be loaded from a pin under reset.
    // The fill wait covers the three flops plus the agreement stage.
    // Writes are refused until the run state, so a host cannot race
    // the default load and have its value overwritten by the strap.
    localparam ST_FILL = 2'd0;
    localparam ST_LOAD = 2'd1;
    localparam ST_RUN = 2'd2;
    reg [1:0] state_r;
    reg [2:0] fill_cnt_r;

    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_r <= ST_FILL;
            fill_cnt_r <= 3'h0;
        end
        else
        begin
            case (state_r)
                ST_FILL:
                begin
                    fill_cnt_r <= fill_cnt_r + 3'h1;
                    if (fill_cnt_r == `FILL_LAST)
                    begin
                        state_r <= ST_LOAD;
                    end
                end
                ST_LOAD:
                    state_r <= ST_RUN;
                ST_RUN:
                    state_r <= ST_RUN;
                default:
                    state_r <= ST_FILL;
            endcase
        end
    end

    // ****************************************
    // Write qualification
    // ****************************************
    reg [7:0] lowlow_r;
    reg [7:0] rx_cfg_r;
    reg perm_lock_r;
    reg clr_lock_r;

    // Locks sample registered state, so the locking write itself lands
    wire locked = perm_lock_r | clr_lock_r;
    wire running = (state_r == ST_RUN);
    wire wr_ok = reg_wr & running & ~locked;

    // Address decode, one select per mapped register
    wire hit_speed = (reg_addr == `REG_EDGE_SPEED);
    wire hit_lowlow = (reg_addr == `REG_LOWLOW_DET);
    wire hit_rx = (reg_addr == `REG_RX_CONFIG);
    wire hit_perm = (reg_addr == `REG_PERM_LOCK);
    wire hit_clr = (reg_addr == `REG_CLR_LOCK);

    // One strobe per register; at most one is high in a cycle
    wire speed_wr = wr_ok & hit_speed;
    wire lowlow_wr = wr_ok & hit_lowlow;
    wire rx_wr = wr_ok & hit_rx;
    wire perm_wr = wr_ok & hit_perm & reg_wdata[`PERM_LOCK_BIT];

    // Clearing the clearable lock must stay possible while it blocks;
    // the toggle lets one register both set and release it, and the
    // permanent lock overrides it.
    wire clr_wr = reg_wr & running & ~perm_lock_r & hit_clr;

    // ****************************************
    // Edge speed register, one flop per output
    // ****************************************
    // One flop per output keeps each edge speed a direct register output
    genvar i;
    generate
        for (i = 0; i < NUM_OUT; i = i + 1)
        begin : g_edge
            always @(posedge clock or posedge rst)
            begin
                if (rst)
                begin
                    out_edge_speed[i] <= 1'b1;
                end
                else if (state_r == ST_LOAD)
                begin
                    out_edge_speed[i] <= src_lvl_r ? 1'b1 : strap_lvl_r;
                end
                else if (speed_wr)
                begin
                    out_edge_speed[i] <= reg_wdata[i];
                end
            end
        end
    endgenerate

    // ****************************************
    // Control and lock registers
    // ****************************************
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            lowlow_r <= `LOWLOW_RESET;
            rx_cfg_r <= `RX_CONFIG_RESET;
            perm_lock_r <= 1'b0;
            clr_lock_r <= 1'b0;
        end
        else
        begin
            if (lowlow_wr)
            begin
                lowlow_r <= reg_wdata;
            end
            if (rx_wr)
            begin
                rx_cfg_r <= reg_wdata;
            end
            // Set-only: no write path ever returns it to 0
            if (perm_wr)
            begin
                perm_lock_r <= 1'b1;
            end
            if (clr_wr && reg_wdata[`CLR_LOCK_BIT])
            begin
                clr_lock_r <= ~clr_lock_r;
            end
        end
    end

    // ****************************************
    // Read path and outputs
    // ****************************************
    reg [7:0] rd_nxt;

    always @*
    begin
        case (reg_addr)
            `REG_EDGE_SPEED: rd_nxt = out_edge_speed;
            `REG_LOWLOW_DET: rd_nxt = lowlow_r;
            `REG_RX_CONFIG: rd_nxt = rx_cfg_r;
            `REG_PERM_LOCK: rd_nxt = {7'h00, perm_lock_r};
            `REG_CLR_LOCK: rd_nxt = {7'h00, clr_lock_r};
            default: rd_nxt = 8'h00;
        endcase
    end

    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
            wr_refused <= 1'b0;
            receiver_off <= 1'b0;
            input_internal_bias_en <= 1'b0;
            input_term_en <= 1'b0;
            any_lock <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            // Read data holds until the next read
            if (reg_rd)
            begin
                reg_rdata <= rd_nxt;
            end
            // A refusal pulse lets the host notice a dropped write
            wr_refused <= reg_wr & ~wr_ok & ~clr_wr;
            // Levels, not edges: a source parked low-low is caught, while a
            // running clock rarely shows both legs low at two samples
            receiver_off <= lowlow_r[`LOWLOW_EN_BIT] & ~pos_lvl_r & ~neg_lvl_r;
            input_internal_bias_en <= rx_cfg_r[`BIAS_EN_BIT];
            input_term_en <= rx_cfg_r[`TERM_EN_BIT];
            any_lock <= locked;
        end
    end

endmodule

`default_nettype wire

// ===== testbench/clock_buffer_config_regs_chk.sv
// Port checker for the configuration register bank.
// Bound onto clock_buffer_config_regs; one clock, rst async high.
`timescale 1ns/1ps
`default_nettype none
module clock_buffer_config_regs_chk #(parameter NUM_OUT = 8) (
    input wire clock,
    input wire rst,
    input wire ref_in_pos,
    input wire ref_in_neg,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire reg_rvalid,
    input wire wr_refused,
    input wire [NUM_OUT-1:0] out_edge_speed,
    input wire receiver_off,
    input wire input_internal_bias_en,
    input wire input_term_en
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("no rvalid");
    a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("stray rvalid");
    a_refusal_cause: assert property (wr_refused |-> $past(reg_wr))
        else $error("stray refusal");
    a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
        else $error("rdata moved");
    a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    // Legs high long enough to pass the synchroniser keep the receiver on
    a_legs_high: assert property ((ref_in_pos && ref_in_neg) [*8] |-> !receiver_off)
        else $error("receiver off with legs high");
    a_config_follow: assert property (reg_wr && reg_addr == 8'h16
        ##1 !wr_refused && !reg_wr
        |=> {input_internal_bias_en, input_term_en} == $past(reg_wdata[1:0], 2))
        else $error("config");
    a_speed_follow: assert property (reg_wr && reg_addr == 8'h14
        ##1 !wr_refused && !reg_wr
        |=> out_edge_speed == $past(reg_wdata, 2))
        else $error("edge speed");
    c_perm_lock: cover property (reg_wr && reg_addr == 8'h17);
    c_refused: cover property (wr_refused);
    c_rx_off: cover property (receiver_off);
endmodule
`default_nettype wire

// ===== testbench/smbus_host_model.sv
// Host model: single-byte register reads and writes on the block's port.
// Drives on a rising edge; holds strobes for exactly one edge.
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
    input wire clock,
    input wire [7:0] reg_rdata,
    input wire reg_rvalid,
    input wire wr_refused,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0;
    task xfer(input w, input [7:0] a, input [7:0] d, output [7:0] q);
        @(posedge clock);
        {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, d, w, !w};
        @(posedge clock);
        {reg_wdata, reg_wr, reg_rd} <= {~d, 2'b00};
        // Answer pulses stand only from the taking edge to the next one
        @(negedge clock);
        q = w ? {7'h0, wr_refused} : (reg_rvalid ? reg_rdata : ~reg_rdata);
    endtask
endmodule
`default_nettype wire

// ===== testbench/test_clock_buffer_config_regs.sv
// Self-checking bench for the configuration register bank.
// Host model drives the register port; straps and legs are driven here.
`timescale 1ns/1ps
`default_nettype none
module test_clock_buffer_config_regs;
    reg clock = 1'b0, rst = 1'b1, slew_default_source_bit = 1'b0, edge_speed_strap = 1'b0;
    reg ref_in_pos = 1'b1, ref_in_neg = 1'b1;
    wire [7:0] reg_addr, reg_wdata, reg_rdata, out_edge_speed;
    wire reg_wr, reg_rd, reg_rvalid, wr_refused, receiver_off;
    wire input_internal_bias_en, input_term_en, any_lock;
    integer miscompares = 0, checks = 0, seed = 82556, i;
    reg [7:0] d, q;
    reg [27:0] e;
    // Entries: write flag, offset, data, expected data or refusal
    localparam [447:0] tab = {112'h0150090_0160000_0170000_0000000,
        112'h1160300_0160003_1160000_1143c00, 112'h1180100_1145a01_1180100_1170100,
        112'h1170001_0170001_114a501_014003c};
    initial forever #5 clock = ~clock;
    clock_buffer_config_regs i_dut (.*);
    smbus_host_model i_host (.*);
    function [7:0] boot_speed(input s, input p);
        boot_speed = s ? 8'hff : {8{p}};
    endfunction
    task cmp(input [7:0] got, input [7:0] exp);
        checks = checks + 1;
        if (got !== exp) miscompares = miscompares + 1;
        if (got !== exp) $display("mismatch at %0t got %h want %h", $time, got, exp);
    endtask
    task io(input w, input [7:0] a, input [7:0] v, input [7:0] exp);
        i_host.xfer(w, a, v, q);
        cmp(q, exp);
    endtask
    task boot(input s, input p);
        @(posedge clock) {rst, slew_default_source_bit, edge_speed_strap} <= {1'b1, s, p};
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        repeat (10) @(negedge clock);
        cmp(out_edge_speed, boot_speed(s, p));
    endtask
    task tally_and_finish;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        boot(1'b0, 1'b0);
        repeat (4)
        begin
            d = $random(seed);
            io(1'b1, 8'h14, d, 8'h00);
            io(1'b0, 8'h14, 8'h00, d);
            cmp(out_edge_speed, d);
        end
        @(posedge clock) {ref_in_pos, ref_in_neg} <= 2'b00;
        repeat (8) @(negedge clock);
        cmp({7'h0, receiver_off}, 8'h01);
        io(1'b1, 8'h15, 8'h90, 8'h00);
        repeat (8) @(negedge clock);
        cmp({7'h0, receiver_off}, 8'h00);
        @(posedge clock) {ref_in_pos, ref_in_neg} <= 2'b11;
        $display("test edge speed and receiver done");
        for (i = 15; i >= 0; i = i - 1)
        begin
            e = tab[i*28 +: 28];
            io(e[24], e[23:16], e[15:8], e[7:0]);
        end
        cmp({7'h0, any_lock}, 8'h01);
        $display("test locks done");
        boot(1'b1, 1'b0);
        boot(1'b0, 1'b1);
        io(1'b0, 8'h17, 8'h00, 8'h00);
        cmp({7'h0, any_lock}, 8'h00);
        $display("test power cycle done");
        tally_and_finish;
    end
    initial
    begin
        repeat (2000) @(posedge clock);
        miscompares = miscompares + 1;
        tally_and_finish;
    end
endmodule
bind clock_buffer_config_regs clock_buffer_config_regs_chk #(.NUM_OUT(NUM_OUT)) i_chk (.*);
`default_nettype wire
